// ==== bench/bmw_link_model.sv ====
// Upstream link model issuing one transaction at a time
`timescale 1ns/1ps
module bmw_link_model (
  // Clock
  input wire logic           clk,
  // Transaction towards the bridge
  output logic               txn_valid,
  output logic               txn_is_mem,
  output bmw_pkg::bmw_addr_t txn_addr
);
  import bmw_pkg::*;
  // Idle lines at time zero
  initial begin
    txn_valid = 1'b0;
    txn_is_mem = 1'b0;
    txn_addr = '0;
  end
  // One cycle of request, then the released lines are scrambled
  task automatic send(input bmw_addr_t a, input logic mem);
    @(negedge clk);
    txn_valid = 1'b1;
    txn_is_mem = mem;
    txn_addr = a;
    @(negedge clk);
    txn_valid = 1'b0;
    txn_is_mem = ~mem;
    txn_addr = ~a;
  endtask : send
endmodule : bmw_link_model

// ==== bench/bmw_regs_sva.sv ====
// Property checker for the memory window register bank
`timescale 1ns/1ps
module bmw_regs_sva (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   sys_rst,
  // Configuration port
  input wire logic                   cfg_rd_en,
  input wire bmw_pkg::bmw_cfg_addr_t cfg_addr,
  input wire bmw_pkg::bmw_dword_t    cfg_rd_data,
  input wire logic                   cfg_rd_valid,
  // Forwarding port
  input wire logic                   txn_valid,
  input wire logic                   txn_is_mem,
  input wire logic                   fwd_valid,
  input wire logic                   fwd_hit,
  input wire logic                   fwd_nonprefetch,
  input wire logic                   fwd_prefetch
);
  import bmw_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Read answer timing and read-only fields
  a_rd_answer_due: assert property (cfg_rd_en |=> cfg_rd_valid)
    else $error("read answer missing");
  a_rd_no_spurious: assert property (cfg_rd_valid |-> $past(cfg_rd_en))
    else $error("read answer without request");
  a_np_rsvd_zero: assert property (cfg_rd_en && cfg_addr[7:2] == 6'h08
    |=> cfg_rd_data[3:0] == 4'h0 && cfg_rd_data[19:16] == 4'h0) else $error("reserved bits set");
  a_pf_wide_flag: assert property (cfg_rd_en && cfg_addr[7:2] == 6'h09
    |=> cfg_rd_data[3:0] == 4'h1 && cfg_rd_data[19:16] == 4'h1) else $error("wide flag wrong");
  // Forwarding decision
  a_hit_is_or: assert property (fwd_hit == (fwd_nonprefetch || fwd_prefetch))
    else $error("hit not the or of windows");
  a_fwd_follows: assert property (fwd_valid == $past(txn_valid))
    else $error("forward valid not one cycle after");
  a_non_mem_miss: assert property (txn_valid && !txn_is_mem
    |=> !fwd_nonprefetch && !fwd_prefetch) else $error("non-memory hit");
  a_hit_needs_txn: assert property (!fwd_valid |-> !fwd_hit)
    else $error("hit without transaction");
  // Main scenarios
  c_read: cover property (cfg_rd_valid);
  c_np_hit: cover property (fwd_nonprefetch);
  c_pf_hit: cover property (fwd_prefetch && !fwd_nonprefetch);
endmodule : bmw_regs_sva

// ==== bench/tb_bmw_regs.sv ====
// Self-checking bench for the memory window register bank
`timescale 1ns/1ps
module tb_bmw_regs;
  import bmw_pkg::*;
  logic          clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          cfg_wr_en = 1'b0;
  logic          cfg_rd_en = 1'b0;
  bmw_cfg_addr_t cfg_addr = '0;
  bmw_byte_en_t  cfg_byte_en = '0;
  bmw_dword_t    cfg_wr_data = '0;
  bmw_dword_t    cfg_rd_data;
  logic          cfg_rd_valid, txn_valid, txn_is_mem;
  bmw_addr_t     txn_addr;
  logic          fwd_valid, fwd_hit, fwd_nonprefetch, fwd_prefetch;
  logic          nonprefetch_enabled, prefetch_enabled;
  bmw_dword_t    m [4];
  bmw_cfg_addr_t wa;
  int            mismatches = 0;
  int            total_checks = 0;
  // Clock, partner and design
  always #10 clk = ~clk;
  bmw_link_model link (.clk, .txn_valid, .txn_is_mem, .txn_addr);
  bmw_regs dut (.clk, .sys_rst, .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_byte_en,
    .cfg_wr_data, .cfg_rd_data, .cfg_rd_valid, .txn_valid, .txn_is_mem, .txn_addr,
    .fwd_valid, .fwd_hit, .fwd_nonprefetch, .fwd_prefetch, .nonprefetch_enabled,
    .prefetch_enabled);
  // Compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Write one dword and mirror it in the model
  task automatic wr(input bmw_cfg_addr_t a, input bmw_byte_en_t be, input bmw_dword_t d);
    int i;
    i = a[3:2];
    @(negedge clk);
    cfg_wr_en = 1'b1;
    cfg_addr = a;
    cfg_byte_en = be;
    cfg_wr_data = d;
    @(negedge clk);
    cfg_wr_en = 1'b0;
    cfg_wr_data = ~d;
    if (a[7:4] == 4'h2) for (int b = 0; b < 4; b++) if (be[b]) m[i][b*8+:8] = d[b*8+:8];
    if (a[7:3] == 5'h04) begin
      m[i][3:0] = {3'b000, i == 1};
      m[i][19:16] = {3'b000, i == 1};
    end
  endtask : wr
  // Read one dword, answer one cycle later
  task automatic rd(input bmw_cfg_addr_t a);
    @(negedge clk);
    cfg_rd_en = 1'b1;
    cfg_addr = a;
    @(negedge clk);
    cfg_rd_en = 1'b0;
    chk(cfg_rd_valid, 1);
    chk(cfg_rd_data, (a[7:4] == 4'h2) ? m[a[3:2]] : 32'h0000_0000);
  endtask : rd
  // Window bounds from the model: np lower, np upper, pf lower, pf upper
  function automatic bmw_addr_t bnd(input int k);
    case (k)
      0: return {32'h0000_0000, m[0][15:4], 20'h0_0000};
      1: return {32'h0000_0000, m[0][31:20], 20'hF_FFFF};
      2: return {m[2], m[1][15:4], 20'h0_0000};
      default: return {m[3], m[1][31:20], 20'hF_FFFF};
    endcase
  endfunction : bnd
  // One transaction against the model decode
  task automatic tx(input bmw_addr_t a, input logic mem);
    logic in_np;
    logic in_pf;
    in_np = a >= bnd(0) && a <= bnd(1);
    in_pf = a >= bnd(2) && a <= bnd(3);
    link.send(a, mem);
    chk(fwd_valid, 1);
    chk(fwd_nonprefetch, mem && in_np);
    chk(fwd_prefetch, mem && in_pf);
    chk(fwd_hit, mem && (in_np || in_pf));
    chk(nonprefetch_enabled, bnd(0) <= bnd(1));
    chk(prefetch_enabled, bnd(2) <= bnd(3));
  endtask : tx
  // Each bound and the address just outside it
  task automatic probe;
    for (int k = 0; k < 4; k++) begin
      tx(bnd(k), 1'b1);
      tx(k[0] ? bnd(k) + 64'h1 : bnd(k) - 64'h1, 1'b1);
    end
  endtask : probe
  // Verdict
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  // Two reset passes, each with reset reads then random programming
  initial begin
    void'($urandom(61));
    for (int r = 0; r < 2; r++) begin
      @(negedge clk);
      sys_rst = 1'b1;
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      m = '{32'h0000_0000, 32'h0001_0001, 32'h0000_0000, 32'h0000_0000};
      for (int a = 8'h20; a <= 8'h30; a += 4) rd(8'(a));
      probe;
      tx(64'h0000_0000_0000_0000, 1'b0);
      for (int n = 0; n < 40; n++) begin
        // Low address bits are ignored by the decode, so scramble them too
        wa = 8'h20 + 8'(4 * $urandom_range(4)) + 8'($urandom_range(3));
        wr(wa, 4'($urandom), $urandom);
        rd(wa);
        probe;
        tx({$urandom, $urandom}, 1'($urandom));
      end
    end
    end_of_test;
  end
  // Watchdog
  initial begin
    #1_000_000;
    mismatches++;
    end_of_test;
  end
endmodule : tb_bmw_regs
bind bmw_regs bmw_regs_sva chk_i (.clk, .sys_rst, .cfg_rd_en, .cfg_addr, .cfg_rd_data,
  .cfg_rd_valid, .txn_valid, .txn_is_mem, .fwd_valid, .fwd_hit, .fwd_nonprefetch,
  .fwd_prefetch);

// ==== rtl/bmw_cfg_reg.sv ====
// Configuration register with byte enables and a writable bit mask
`timescale 1ns/1ps
module bmw_cfg_reg #(
  parameter logic [31:0] RST_VAL = 32'h0000_0000,
  parameter logic [31:0] WR_MASK = 32'hFFFF_FFFF
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Write port
  input  wire logic              wr_en,
  input  wire bmw_pkg::bmw_byte_en_t byte_en,
  input  wire bmw_pkg::bmw_dword_t   wr_data,
  // Stored value
  output bmw_pkg::bmw_dword_t        q
);
  import bmw_pkg::*;

  bmw_dword_t q_reg;
  bmw_dword_t q_next;
  bmw_dword_t lane_mask;

  // Lanes written this cycle, limited to writable bits
  assign lane_mask = {{8{byte_en[3]}}, {8{byte_en[2]}}, {8{byte_en[1]}}, {8{byte_en[0]}}}
                     & WR_MASK;
  assign q_next    = wr_en ? ((wr_data & lane_mask) | (q_reg & ~lane_mask)) : q_reg;
  assign q         = q_reg;

  // Storage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_reg <= RST_VAL;
    end else begin
      q_reg <= q_next;
    end
  end

endmodule : bmw_cfg_reg

// ==== rtl/bmw_params.svh ====
// Offsets, field positions and reset values of the memory window registers
`ifndef BMW_PARAMS_SVH
`define BMW_PARAMS_SVH

// Configuration offsets (byte addresses as printed)
`define BMW_OFS_MEM_LOWER      8'h20
`define BMW_OFS_MEM_UPPER      8'h22
`define BMW_OFS_PF_LOWER       8'h24
`define BMW_OFS_PF_UPPER       8'h26
`define BMW_OFS_PF_LOWER_HI    8'h28
`define BMW_OFS_PF_UPPER_HI    8'h2C

// Granule field position inside each 16-bit bound register
`define BMW_GRAN_MSB           15
`define BMW_GRAN_LSB           4

// Implied low address bits of lower and upper bounds
`define BMW_LOW_FILL_LOWER     20'h0_0000
`define BMW_LOW_FILL_UPPER     20'hF_FFFF

// Reset values of the 16-bit registers and of the 32-bit upper dwords
`define BMW_RST_MEM_LOWER      16'h0000
`define BMW_RST_MEM_UPPER      16'h0000
`define BMW_RST_PF_LOWER       16'h0001
`define BMW_RST_PF_UPPER       16'h0001
`define BMW_RST_PF_HI          32'h0000_0000

// Writable bit masks; clear bits hold their reset value
`define BMW_MASK_BOUND16       16'hFFF0
`define BMW_MASK_FULL32        32'hFFFF_FFFF

`endif

// ==== rtl/bmw_pkg.sv ====
// Types and bound builder shared by the memory window register bank
package bmw_pkg;

  typedef logic [63:0] bmw_addr_t;
  typedef logic [31:0] bmw_dword_t;
  typedef logic [7:0]  bmw_cfg_addr_t;
  typedef logic [3:0]  bmw_byte_en_t;
  typedef logic [11:0] bmw_gran_t;

  // Full 64-bit bound from upper dword, granule and implied low bits
  function automatic bmw_addr_t bmw_bound(input bmw_dword_t hi, input bmw_gran_t gran,
                                          input logic [19:0] low);
    bmw_bound = {hi, gran, low};
  endfunction : bmw_bound

endpackage : bmw_pkg

// ==== rtl/bmw_regs.sv ====
// Memory window configuration registers and downstream forwarding decode
`timescale 1ns/1ps
`include "bmw_params.svh"
module bmw_regs (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // Configuration access, one dword per access
  input  wire logic                  cfg_wr_en,
  input  wire logic                  cfg_rd_en,
  input  wire bmw_pkg::bmw_cfg_addr_t cfg_addr,
  input  wire bmw_pkg::bmw_byte_en_t  cfg_byte_en,
  input  wire bmw_pkg::bmw_dword_t    cfg_wr_data,
  output bmw_pkg::bmw_dword_t         cfg_rd_data,
  output logic                       cfg_rd_valid,
  // Upstream memory transaction
  input  wire logic                  txn_valid,
  input  wire logic                  txn_is_mem,
  input  wire bmw_pkg::bmw_addr_t    txn_addr,
  // Forwarding decision
  output logic                       fwd_valid,
  output logic                       fwd_hit,
  output logic                       fwd_nonprefetch,
  output logic                       fwd_prefetch,
  // Window state
  output logic                       nonprefetch_enabled,
  output logic                       prefetch_enabled
);
  import bmw_pkg::*;

  // Dword addresses of the register groups
  localparam logic [5:0] DW_MEM      = 6'(`BMW_OFS_MEM_LOWER >> 2);
  localparam logic [5:0] DW_PF       = 6'(`BMW_OFS_PF_LOWER >> 2);
  localparam logic [5:0] DW_PF_LO_HI = 6'(`BMW_OFS_PF_LOWER_HI >> 2);
  localparam logic [5:0] DW_PF_UP_HI = 6'(`BMW_OFS_PF_UPPER_HI >> 2);

  // Dword images: lower bound in low half, upper bound in high half
  localparam logic [31:0] RST_MEM  = {`BMW_RST_MEM_UPPER, `BMW_RST_MEM_LOWER};
  localparam logic [31:0] RST_PF   = {`BMW_RST_PF_UPPER, `BMW_RST_PF_LOWER};
  localparam logic [31:0] MASK_BND = {`BMW_MASK_BOUND16, `BMW_MASK_BOUND16};

  bmw_dword_t mem_dw;
  bmw_dword_t pf_dw;
  bmw_dword_t pf_lower_hi;
  bmw_dword_t pf_upper_hi;

  logic [5:0]  cfg_dw;
  logic        sel_mem;
  logic        sel_pf;
  logic        sel_pf_lo_hi;
  logic        sel_pf_up_hi;

  bmw_gran_t   nonprefetch_lower_field;
  bmw_gran_t   nonprefetch_upper_field;
  bmw_gran_t   prefetch_lower_field;
  bmw_gran_t   prefetch_upper_field;
  logic [3:0]  wide_address_indicator;

  bmw_addr_t   np_lower;
  bmw_addr_t   np_upper;
  bmw_addr_t   pf_lower;
  bmw_addr_t   pf_upper;
  logic        np_en;
  logic        pf_en;
  logic        np_hit;
  logic        pf_hit;

  bmw_dword_t  cfg_rd_data_reg;
  bmw_dword_t  cfg_rd_data_next;
  logic        cfg_rd_valid_reg;
  logic        fwd_valid_reg;
  logic        fwd_hit_reg;
  logic        fwd_np_reg;
  logic        fwd_pf_reg;
  logic        np_en_reg;
  logic        pf_en_reg;

  // Address decode of a configuration access
  assign cfg_dw       = cfg_addr[7:2];
  assign sel_mem      = (cfg_dw == DW_MEM);
  assign sel_pf       = (cfg_dw == DW_PF);
  assign sel_pf_lo_hi = (cfg_dw == DW_PF_LO_HI);
  assign sel_pf_up_hi = (cfg_dw == DW_PF_UP_HI);

  // Non-prefetchable bounds, reserved nibbles held at zero
  bmw_cfg_reg #(
    .RST_VAL (RST_MEM),
    .WR_MASK (MASK_BND)
  ) u_mem_reg (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (cfg_wr_en && sel_mem),
    .byte_en (cfg_byte_en),
    .wr_data (cfg_wr_data),
    .q       (mem_dw)
  );

  // Prefetchable bounds, indicator nibbles read-only
  bmw_cfg_reg #(
    .RST_VAL (RST_PF),
    .WR_MASK (MASK_BND)
  ) u_pf_reg (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (cfg_wr_en && sel_pf),
    .byte_en (cfg_byte_en),
    .wr_data (cfg_wr_data),
    .q       (pf_dw)
  );

  // Prefetchable lower bound, address bits 63:32
  bmw_cfg_reg #(
    .RST_VAL (`BMW_RST_PF_HI),
    .WR_MASK (`BMW_MASK_FULL32)
  ) u_pf_lo_hi_reg (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (cfg_wr_en && sel_pf_lo_hi),
    .byte_en (cfg_byte_en),
    .wr_data (cfg_wr_data),
    .q       (pf_lower_hi)
  );

  // Prefetchable upper bound, address bits 63:32
  bmw_cfg_reg #(
    .RST_VAL (`BMW_RST_PF_HI),
    .WR_MASK (`BMW_MASK_FULL32)
  ) u_pf_up_hi_reg (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (cfg_wr_en && sel_pf_up_hi),
    .byte_en (cfg_byte_en),
    .wr_data (cfg_wr_data),
    .q       (pf_upper_hi)
  );

  // Granule fields out of the stored dwords
  assign nonprefetch_lower_field = mem_dw[`BMW_GRAN_MSB:`BMW_GRAN_LSB];
  assign nonprefetch_upper_field = mem_dw[16+`BMW_GRAN_MSB:16+`BMW_GRAN_LSB];
  assign prefetch_lower_field    = pf_dw[`BMW_GRAN_MSB:`BMW_GRAN_LSB];
  assign prefetch_upper_field    = pf_dw[16+`BMW_GRAN_MSB:16+`BMW_GRAN_LSB];
  assign wide_address_indicator  = pf_dw[3:0];

  // Full 64-bit bounds; non-prefetchable window lives below 4 GB
  assign np_lower = bmw_bound(32'h0000_0000, nonprefetch_lower_field,
                              `BMW_LOW_FILL_LOWER);
  assign np_upper = bmw_bound(32'h0000_0000, nonprefetch_upper_field,
                              `BMW_LOW_FILL_UPPER);
  assign pf_lower = bmw_bound(pf_lower_hi, prefetch_lower_field,
                              `BMW_LOW_FILL_LOWER);
  assign pf_upper = bmw_bound(pf_upper_hi, prefetch_upper_field,
                              `BMW_LOW_FILL_UPPER);

  // Non-prefetchable window compare
  bmw_win_cmp u_np_cmp (
    .lower   (np_lower),
    .upper   (np_upper),
    .addr    (txn_addr),
    .enabled (np_en),
    .hit     (np_hit)
  );

  // Prefetchable window compare
  bmw_win_cmp u_pf_cmp (
    .lower   (pf_lower),
    .upper   (pf_upper),
    .addr    (txn_addr),
    .enabled (pf_en),
    .hit     (pf_hit)
  );

  // Read data selection; unmapped dwords read zero
  assign cfg_rd_data_next = sel_mem      ? mem_dw :
                            sel_pf       ? {pf_dw[31:4], wide_address_indicator} :
                            sel_pf_lo_hi ? pf_lower_hi :
                            sel_pf_up_hi ? pf_upper_hi :
                            32'h0000_0000;

  // Configuration read answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_rd_data_reg  <= 32'h0000_0000;
      cfg_rd_valid_reg <= 1'b0;
    end else begin
      cfg_rd_valid_reg <= cfg_rd_en;
      cfg_rd_data_reg  <= cfg_rd_en ? cfg_rd_data_next : 32'h0000_0000;
    end
  end

  // Forwarding decision; fwd_valid follows every transaction, hits for memory transactions only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fwd_valid_reg <= 1'b0;
      fwd_hit_reg   <= 1'b0;
      fwd_np_reg    <= 1'b0;
      fwd_pf_reg    <= 1'b0;
    end else begin
      fwd_valid_reg <= txn_valid;
      fwd_np_reg    <= txn_valid && txn_is_mem && np_hit;
      fwd_pf_reg    <= txn_valid && txn_is_mem && pf_hit;
      fwd_hit_reg   <= txn_valid && txn_is_mem && (np_hit || pf_hit);
    end
  end

  // Window enable status
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      np_en_reg <= 1'b0;
      pf_en_reg <= 1'b0;
    end else begin
      np_en_reg <= np_en;
      pf_en_reg <= pf_en;
    end
  end

  // Outputs straight from flops
  assign cfg_rd_data         = cfg_rd_data_reg;
  assign cfg_rd_valid        = cfg_rd_valid_reg;
  assign fwd_valid           = fwd_valid_reg;
  assign fwd_hit             = fwd_hit_reg;
  assign fwd_nonprefetch     = fwd_np_reg;
  assign fwd_prefetch        = fwd_pf_reg;
  assign nonprefetch_enabled = np_en_reg;
  assign prefetch_enabled    = pf_en_reg;

endmodule : bmw_regs

// ==== rtl/bmw_win_cmp.sv ====
// Inclusive 64-bit address window compare with empty-window detect
`timescale 1ns/1ps
module bmw_win_cmp (
  // Window bounds
  input  wire bmw_pkg::bmw_addr_t lower,
  input  wire bmw_pkg::bmw_addr_t upper,
  // Address under test
  input  wire bmw_pkg::bmw_addr_t addr,
  // Results
  output logic                    enabled,
  output logic                    hit
);
  import bmw_pkg::*;

  // A lower bound above the upper bound closes the window
  assign enabled = (lower <= upper);
  assign hit     = enabled && (addr >= lower) && (addr <= upper);

endmodule : bmw_win_cmp
